// >>> bench/geirq_host_model.sv
// Host-side model of the pulled-up open-drain interrupt line
`timescale 1ns/1ps
module geirq_host_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic irq_oe_n,
  output logic      irq_line,
  output logic      irq_seen
);
  // ==========================================================================
  // Wire level
  // ==========================================================================
  // Pull-up takes the line high whenever the device lets go of it
  assign irq_line = irq_oe_n ? 1'b1 : 1'b0;

  // Host latches any low level; only a reset forgets it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_seen <= 1'b0;
    end else if (!irq_line) begin
      irq_seen <= 1'b1;
    end
  end
endmodule : geirq_host_model

// >>> bench/tb.sv
// Self-checking testbench of the edge event block over APB
`timescale 1ns/1ps
module tb
  import geirq_pkg::*;
;
  logic              clk;
  logic              rst_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic [3:0]        pstrb;
  logic              pready;
  logic              pslverr;
  logic [LINES-1:0]  io_in;
  logic              irq_out_n;
  logic              irq_out_oe_n;
  logic              irq_line;
  logic              irq_seen;
  logic [DATA_W-1:0] rd;
  logic              err;
  int                fails;
  int                checked;

  geirq_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .io_in(io_in), .irq_out_n(irq_out_n), .irq_out_oe_n(irq_out_oe_n));
  geirq_host_model host (.clk(clk), .rst_n(rst_n), .irq_oe_n(irq_out_oe_n),
    .irq_line(irq_line), .irq_seen(irq_seen));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // An idle edge first, so psel is never assigned twice in one time step
  task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic expect_reg(input string what, input logic [IDX_W-1:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(what, rd, {24'h000000, exp});
  endtask : expect_reg

  task automatic expect_irq(input logic exp);
    @(negedge clk);
    check("irq line", {31'h0, irq_line}, {31'h0, exp});
    check("irq pin", {31'h0, irq_out_n}, {31'h0, exp});
  endtask : expect_irq

  // Two synchroniser flops plus compare need a few edges before flags show
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask : settle

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset;
    expect_reg("mask high", IDX_MASK_HIGH, 8'hff);
    expect_reg("mask low", IDX_MASK_LOW, 8'hff);
    expect_reg("sense low a", IDX_SENSE_LOW_A, 8'h00);
    expect_reg("src high", IDX_SRC_HIGH, 8'h00);
    expect_reg("src low", IDX_SRC_LOW, 8'h00);
    expect_reg("evt high", IDX_EVT_HIGH, 8'h00);
    expect_reg("evt low", IDX_EVT_LOW, 8'h00);
    apb(1'b0, 6'h12, 8'h00);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    expect_irq(1'b1);
  endtask : t_reset

  // Line 8 rises while its sense is still none, so nothing may be flagged
  task automatic t_config;
    io_in[8] <= 1'b1;
    settle();
    expect_reg("evt high none", IDX_EVT_HIGH, 8'h00);
    apb(1'b1, IDX_SENSE_LOW_A, 8'hd0);
    apb(1'b1, IDX_SENSE_LOW_B, 8'h02);
    apb(1'b1, IDX_MASK_LOW, 8'hfa);
    apb(1'b1, IDX_MASK_HIGH, 8'hfe);
    pstrb <= 4'h0;
    apb(1'b1, IDX_MASK_LOW, 8'h00);
    pstrb <= 4'h1;
    expect_reg("mask no strobe", IDX_MASK_LOW, 8'hfa);
    expect_reg("sense low a", IDX_SENSE_LOW_A, 8'hd0);
  endtask : t_config

  task automatic t_edges;
    io_in <= 16'h010d;
    settle();
    expect_reg("evt low rise", IDX_EVT_LOW, 8'h0c);
    expect_reg("src low masked", IDX_SRC_LOW, 8'h04);
    expect_irq(1'b0);
    io_in <= 16'h000d;
    settle();
    expect_reg("evt high fall", IDX_EVT_HIGH, 8'h01);
    expect_reg("src high fall", IDX_SRC_HIGH, 8'h01);
  endtask : t_edges

  task automatic t_clear;
    apb(1'b1, IDX_SRC_LOW, 8'h00);
    expect_reg("src low kept", IDX_SRC_LOW, 8'h04);
    apb(1'b1, IDX_SRC_LOW, 8'h04);
    expect_reg("src low cleared", IDX_SRC_LOW, 8'h00);
    expect_reg("evt low paired", IDX_EVT_LOW, 8'h08);
    expect_irq(1'b0);
    apb(1'b1, IDX_EVT_HIGH, 8'h01);
    expect_reg("evt high cleared", IDX_EVT_HIGH, 8'h00);
    expect_reg("src high paired", IDX_SRC_HIGH, 8'h00);
    expect_irq(1'b1);
  endtask : t_clear

  task automatic t_sense;
    apb(1'b1, IDX_SENSE_LOW_A, 8'h50);
    expect_reg("evt low sense change", IDX_EVT_LOW, 8'h00);
    io_in <= 16'h0009;
    settle();
    expect_reg("evt low no fall", IDX_EVT_LOW, 8'h00);
    apb(1'b1, IDX_SENSE_LOW_A, 8'hd0);
    io_in <= 16'h0001;
    settle();
    expect_reg("evt low both", IDX_EVT_LOW, 8'h08);
    expect_irq(1'b1);
    apb(1'b1, IDX_EVT_LOW, 8'h08);
    expect_reg("evt low w1c", IDX_EVT_LOW, 8'h00);
    check("host saw irq", {31'h0, irq_seen}, 32'h1);
  endtask : t_sense

  // ==========================================================================
  // Run control
  // ==========================================================================
  task automatic stop_test;
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Whole sequence needs well under 1000 cycles
  initial begin
    #100000;
    fails++;
    stop_test();
  end

  initial begin
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h00000000;
    pstrb   = 4'h1;
    io_in   = 16'h0000;
    fails   = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_config();
    t_edges();
    t_clear();
    t_sense();
    stop_test();
  end
endmodule : tb

// >>> src/geirq_edge_detect.sv
// Pin synchroniser and per-line edge detector with selectable sense
`timescale 1ns/1ps
module geirq_edge_detect
  import geirq_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [LINES-1:0]   pin_in,
  input  wire logic [SENSE_W-1:0] sense,
  output logic      [LINES-1:0]   hit
);

  geirq_sync_t r;
  geirq_sync_t next_r;

  // ==========================================================================
  // Synchroniser; s1 feeds only s2
  // ==========================================================================
  always_comb begin
    next_r      = r;
    next_r.s1   = pin_in;
    next_r.s2   = r.s1;
    next_r.prev = r.s2;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // Edge match
  // ==========================================================================
  always_comb begin
    hit = '0;
    for (int i = 0; i < LINES; i++) begin
      case (sense[2*i +: 2])
        SENSE_RISING:  hit[i] = r.s2[i] & ~r.prev[i];
        SENSE_FALLING: hit[i] = ~r.s2[i] & r.prev[i];
        SENSE_BOTH:    hit[i] = r.s2[i] ^ r.prev[i];
        default:       hit[i] = 1'b0;
      endcase
    end
  end

endmodule : geirq_edge_detect

// >>> src/geirq_pkg.sv
// Package: register map, field layout, reset values and state types of the edge event block
package geirq_pkg;

  // ==========================================================================
  // Sizes
  // ==========================================================================
  localparam int LINES   = 16;
  localparam int SENSE_W = 2 * LINES;
  localparam int BANK_W  = 8;
  localparam int IDX_W   = 6;
  localparam int DATA_W  = 32;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  // ==========================================================================
  localparam logic [IDX_W-1:0] IDX_MASK_HIGH    = 6'h08;
  localparam logic [IDX_W-1:0] IDX_MASK_LOW     = 6'h09;
  localparam logic [IDX_W-1:0] IDX_SENSE_HIGH_B = 6'h0a;
  localparam logic [IDX_W-1:0] IDX_SENSE_HIGH_A = 6'h0b;
  localparam logic [IDX_W-1:0] IDX_SENSE_LOW_B  = 6'h0c;
  localparam logic [IDX_W-1:0] IDX_SENSE_LOW_A  = 6'h0d;
  localparam logic [IDX_W-1:0] IDX_SRC_HIGH     = 6'h0e;
  localparam logic [IDX_W-1:0] IDX_SRC_LOW      = 6'h0f;
  localparam logic [IDX_W-1:0] IDX_EVT_HIGH     = 6'h10;
  localparam logic [IDX_W-1:0] IDX_EVT_LOW      = 6'h11;

  // Bank A holds lines 7:0, bank B lines 15:8
  localparam int BANK_LOW_BASE  = 0;
  localparam int BANK_HIGH_BASE = 8;

  // Bit position of each sense register inside the 32-bit sense vector
  localparam int SENSE_LOW_A_BASE  = 0;
  localparam int SENSE_HIGH_A_BASE = 8;
  localparam int SENSE_LOW_B_BASE  = 16;
  localparam int SENSE_HIGH_B_BASE = 24;

  // ==========================================================================
  // Sense codes and reset values
  // ==========================================================================
  localparam logic [1:0] SENSE_NONE    = 2'h0;
  localparam logic [1:0] SENSE_RISING  = 2'h1;
  localparam logic [1:0] SENSE_FALLING = 2'h2;
  localparam logic [1:0] SENSE_BOTH    = 2'h3;

  localparam logic [SENSE_W-1:0] SENSE_RST = 32'h0000_0000;
  localparam logic [LINES-1:0]   MASK_RST  = 16'hffff;
  localparam logic [LINES-1:0]   FLAG_RST  = 16'h0000;
  localparam logic [DATA_W-1:0]  DATA_RST  = 32'h0000_0000;

  // ==========================================================================
  // State types
  // ==========================================================================
  typedef struct packed {
    logic [LINES-1:0] s1;
    logic [LINES-1:0] s2;
    logic [LINES-1:0] prev;
  } geirq_sync_t;

  typedef struct packed {
    logic [SENSE_W-1:0] sense;
    logic [LINES-1:0]   mask;
    logic [LINES-1:0]   evt;
    logic [LINES-1:0]   src;
    logic [DATA_W-1:0]  rdata;
    logic               irq_n;
  } geirq_state_t;

  // ==========================================================================
  // Decoding
  // ==========================================================================
  function automatic int geirq_sense_base(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_SENSE_HIGH_B: return SENSE_HIGH_B_BASE;
      IDX_SENSE_HIGH_A: return SENSE_HIGH_A_BASE;
      IDX_SENSE_LOW_B:  return SENSE_LOW_B_BASE;
      default:          return SENSE_LOW_A_BASE;
    endcase
  endfunction : geirq_sense_base

  function automatic logic geirq_idx_valid(input logic [IDX_W-1:0] idx);
    return (idx >= IDX_MASK_HIGH) && (idx <= IDX_EVT_LOW);
  endfunction : geirq_idx_valid

endpackage : geirq_pkg

// >>> src/geirq_top.sv
// Edge event and interrupt source block with APB register access
//
// Behaviour
// - Two-bit sense per line: none/rise/fall/both
// - Matching edge sets event bit regardless mask
// - Unmasked matching edge sets interrupt source bit
// - Writing one to source clears source and event
// - Writing one to event clears event and source
// - Interrupt releases high only when sources clear
// - Sense change clears that line's event bit
// - Mask zero enables, one blocks; resets ones
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module geirq_top
  import geirq_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [LINES-1:0]  io_in,
  output logic                   irq_out_n,
  output logic                   irq_out_oe_n
);

  geirq_state_t       r;
  geirq_state_t       next_r;
  logic [LINES-1:0]   hit;
  logic [LINES-1:0]   clr;
  logic [LINES-1:0]   chg;
  logic [IDX_W-1:0]   idx;
  logic               wr_en;
  logic               rd_setup;
  logic [BANK_W-1:0]  wbyte;
  logic [BANK_W-1:0]  rbyte;

  // ==========================================================================
  // Edge detection
  // ==========================================================================
  geirq_edge_detect u_edge (
    .clk    (clk),
    .rst_n  (rst_n),
    .pin_in (io_in),
    .sense  (r.sense),
    .hit    (hit)
  );

  // ==========================================================================
  // APB handshake
  // ==========================================================================
  // Zero wait states: read data is captured in the setup cycle
  // A write without pstrb[0] is dropped silently; upper lanes carry nothing
  // Unmapped index: error in the access phase, write dropped, read gives zero
  assign idx      = paddr[7:2];
  assign wbyte    = pwdata[BANK_W-1:0];
  assign wr_en    = psel & penable & pwrite & pstrb[0] & geirq_idx_valid(idx);
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~geirq_idx_valid(idx);
  assign prdata   = r.rdata;

  // Open drain: enable low while pulling low, released otherwise
  assign irq_out_n    = r.irq_n;
  assign irq_out_oe_n = r.irq_n;

  // ==========================================================================
  // Register read
  // ==========================================================================
  // Reads have no side effect; flags fall only by write-one or sense change
  always_comb begin
    rbyte = '0;
    case (idx)
      IDX_MASK_HIGH:    rbyte = r.mask[BANK_HIGH_BASE +: BANK_W];
      IDX_MASK_LOW:     rbyte = r.mask[BANK_LOW_BASE +: BANK_W];
      IDX_SENSE_HIGH_B,
      IDX_SENSE_HIGH_A,
      IDX_SENSE_LOW_B,
      IDX_SENSE_LOW_A:  rbyte = r.sense[geirq_sense_base(idx) +: BANK_W];
      IDX_SRC_HIGH:     rbyte = r.src[BANK_HIGH_BASE +: BANK_W];
      IDX_SRC_LOW:      rbyte = r.src[BANK_LOW_BASE +: BANK_W];
      IDX_EVT_HIGH:     rbyte = r.evt[BANK_HIGH_BASE +: BANK_W];
      IDX_EVT_LOW:      rbyte = r.evt[BANK_LOW_BASE +: BANK_W];
      default:          rbyte = '0;
    endcase
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    next_r = r;
    clr    = '0;
    chg    = '0;
    if (rd_setup) begin
      next_r.rdata = {{(DATA_W-BANK_W){1'b0}}, rbyte};
    end
    if (wr_en) begin
      case (idx)
        IDX_MASK_HIGH:    next_r.mask[BANK_HIGH_BASE +: BANK_W] = wbyte;
        IDX_MASK_LOW:     next_r.mask[BANK_LOW_BASE +: BANK_W]  = wbyte;
        IDX_SENSE_HIGH_B,
        IDX_SENSE_HIGH_A,
        IDX_SENSE_LOW_B,
        IDX_SENSE_LOW_A:  next_r.sense[geirq_sense_base(idx) +: BANK_W] = wbyte;
        IDX_SRC_HIGH,
        IDX_EVT_HIGH:     clr[BANK_HIGH_BASE +: BANK_W] = wbyte;
        IDX_SRC_LOW,
        IDX_EVT_LOW:      clr[BANK_LOW_BASE +: BANK_W]  = wbyte;
        default:          clr = '0;
      endcase
    end
    // Rewriting the same sense code is no change and keeps the flags
    for (int i = 0; i < LINES; i++) begin
      chg[i] = next_r.sense[2*i +: 2] != r.sense[2*i +: 2];
    end
    // New edges win over a clear in the same cycle
    next_r.evt   = (r.evt & ~clr & ~chg) | hit;
    next_r.src   = (r.src & ~clr) | (hit & ~r.mask);
    next_r.irq_n = ~|next_r.src;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r.sense <= SENSE_RST;
      r.mask  <= MASK_RST;
      r.evt   <= FLAG_RST;
      r.src   <= FLAG_RST;
      r.rdata <= DATA_RST;
      r.irq_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_line2_sense_gate: assert property (@(posedge clk) disable iff (!rst_n)
    hit[2] |-> r.sense[5:4] != SENSE_NONE)
    else $error("Line 2 edge seen with sense set to none");

  a_edge_sets_event: assert property (@(posedge clk) disable iff (!rst_n)
    hit != '0 |=> (r.evt & $past(hit)) == $past(hit))
    else $error("Matching edge did not set event bit");

  a_edge_sets_source: assert property (@(posedge clk) disable iff (!rst_n)
    (hit & ~r.mask) != '0 |=> (r.src & $past(hit & ~r.mask)) == $past(hit & ~r.mask))
    else $error("Unmasked edge did not set source bit");

  a_src_clear_both: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && idx == IDX_SRC_LOW && hit == '0
    |=> (r.src[7:0] & $past(wbyte)) == '0 && (r.evt[7:0] & $past(wbyte)) == '0)
    else $error("Source write did not clear source and event");

  a_evt_clear_both: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && idx == IDX_EVT_HIGH && hit == '0
    |=> (r.src[15:8] & $past(wbyte)) == '0 && (r.evt[15:8] & $past(wbyte)) == '0)
    else $error("Event write did not clear event and source");

  a_irq_release: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(irq_out_n) |-> r.src == '0 && $past(r.src) != '0)
    else $error("Interrupt released while a source is set");

  a_sense_chg_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (chg & ~hit) != '0 |=> (r.evt & $past(chg & ~hit)) == '0)
    else $error("Sense change left event bit set");

  a_mask_blocks_src: assert property (@(posedge clk) disable iff (!rst_n)
    ((r.src & ~$past(r.src)) & $past(r.mask)) == '0)
    else $error("Masked line raised a source bit");

  a_irq_held_low: assert property (@(posedge clk) disable iff (!rst_n)
    r.src != '0 |-> !irq_out_n && !irq_out_oe_n)
    else $error("Interrupt not driven low with source set");

  // Flags only fall through a write-one or a sense change
  a_src_fall_cause: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(r.src) & ~r.src & ~$past(clr)) == '0)
    else $error("Source bit fell without a clear");

  a_evt_fall_cause: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(r.evt) & ~r.evt & ~$past(clr | chg)) == '0)
    else $error("Event bit fell without a clear or sense change");

  // A newly set source bit implies the event bit of its line
  a_src_has_evt: assert property (@(posedge clk) disable iff (!rst_n)
    (r.src & ~$past(r.src) & ~r.evt) == '0)
    else $error("Source bit set without its event bit");

  a_mask_write_only: assert property (@(posedge clk) disable iff (!rst_n)
    r.mask != $past(r.mask) |-> $past(wr_en) && ($past(idx) == IDX_MASK_HIGH || $past(idx) == IDX_MASK_LOW))
    else $error("Mask changed without a mask write");

  a_sense_write_only: assert property (@(posedge clk) disable iff (!rst_n)
    r.sense != $past(r.sense) |-> $past(wr_en) && $past(idx) >= IDX_SENSE_HIGH_B && $past(idx) <= IDX_SENSE_LOW_A)
    else $error("Sense changed without a sense write");

  a_strb_gate: assert property (@(posedge clk) disable iff (!rst_n)
    psel && penable && pwrite && !pstrb[0] |=> $stable(r.mask) && $stable(r.sense))
    else $error("Write without byte strobe changed a register");

  a_read_capture: assert property (@(posedge clk) disable iff (!rst_n)
    rd_setup && idx == IDX_EVT_LOW |=> prdata == {{(DATA_W-BANK_W){1'b0}}, $past(r.evt[BANK_LOW_BASE +: BANK_W])})
    else $error("Event read did not return the captured event bits");

  // ==========================================================================
  // Covers
  // ==========================================================================
  c_irq_raised:  cover property (@(posedge clk) disable iff (!rst_n) $fell(irq_out_n));
  c_unmapped:    cover property (@(posedge clk) disable iff (!rst_n) pslverr);
  c_src_cleared: cover property (@(posedge clk) disable iff (!rst_n)
    wr_en && idx == IDX_SRC_LOW ##1 $rose(irq_out_n));
  c_sense_chg:   cover property (@(posedge clk) disable iff (!rst_n) (chg & r.evt) != '0);
  c_masked_evt:  cover property (@(posedge clk) disable iff (!rst_n) (hit & r.mask) != '0);

endmodule : geirq_top
